//--- include/conv_regs_pkg.sv
// Register map, field layout, reset values and carrier types of the converter control bank
package conv_regs_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_BOOST_CONTROL = 10'h0b7;
  localparam logic [9:0] IDX_BOOST_SEQUENCING = 10'h0b8;
  localparam logic [9:0] IDX_THIRD_CONTROL = 10'h0ba;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h0c0;
  localparam logic [9:0] IDX_IRQ_CLEAR = 10'h0c1;
  localparam logic [9:0] IDX_IRQ_ENABLE = 10'h0c2;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int IRQ_W = 2;

  // Boost converter control fields
  localparam int C2_TOPOLOGY_BIT = 14;
  localparam int C2_SLEEP_RESP_BIT = 12;
  localparam int C2_SLEEP_SRC_LSB = 8;
  localparam int C2_PEAK_LIMIT_BIT = 6;
  localparam int C2_RAMP_HI_BIT = 4;
  localparam int C2_RAMP_LO_BIT = 3;
  localparam int C2_FEEDBACK_LSB = 0;
  // Sequencing fields
  localparam int C2_FAULT_ACT_LSB = 14;
  localparam int C2_UP_SLOT_LSB = 10;
  localparam int C2_DOWN_SLOT_LSB = 6;
  // Third converter fields
  localparam int C3_OVP_OFF_BIT = 11;
  localparam int C3_FLOAT_BIT = 10;
  localparam int C3_VOLT_LSB = 0;

  // Implemented bits per register
  localparam logic [15:0] MASK_BOOST_CONTROL = 16'h535b;
  localparam logic [15:0] MASK_BOOST_SEQUENCING = 16'hffc0;
  localparam logic [15:0] MASK_THIRD_CONTROL = 16'h0c7f;

  localparam logic [15:0] RST_BOOST_CONTROL = 16'h0018;
  localparam logic [15:0] RST_BOOST_SEQUENCING = 16'h0000;
  localparam logic [6:0] RST_THIRD_VOLT = 7'h00;

  localparam logic [1:0] FB_INTERNAL_DIVIDER = 2'h3;
  localparam logic [1:0] RAMP_LOWEST = 2'h3;
  localparam logic [1:0] FAULT_IGNORE = 2'h0;
  localparam logic [1:0] FAULT_CONV_OFF = 2'h1;
  localparam logic [3:0] SLOT_NEVER = 4'h0;
  localparam logic [3:0] SLOT_ALL_ONES = 4'hf;
  localparam logic [6:0] VOLT_CODE_MAX = 7'h66;

  localparam int IRQ_FAULT = 0;
  localparam int IRQ_SLEEP = 1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic switch_mode;
    logic sleep_selected;
    logic output_disabled;
    logic low_peak_limit;
    logic [1:0] ramp_range;
    logic [1:0] feedback_source;
    logic [3:0] up_slot;
    logic up_never;
    logic up_on_active;
    logic [3:0] down_slot;
    logic down_on_off_entry;
    logic shutdown_converter;
    logic shutdown_system;
  } conv2_ctrl_t;

  typedef struct packed {
    logic overvolt_protect_en;
    logic discharge_en;
    logic [6:0] voltage_code;
  } conv3_ctrl_t;

endpackage

//--- logic/converter_control_regs.sv
// Converter control register bank with AXI4-Lite slave and fault interrupt
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ns
// Operation
// - bit 14 picks boost or switch mode
// - bit 12: sleep keeps running or disables
// - bits 9:8 choose sleep source
// - hibernate pin input forces sleep selection
// - bit 6 chooses high or low peak
// - bits 4:3 pick compensation ramp range
// - feedback code 11 forces lowest ramp
// - bits 1:0 choose feedback source
// - bits 15:14 choose fault action
// - every fault edge sets the status flag, even ignored; irq only when enabled
// - bits 13:10 schedule power-up slot
// - bits 9:6 schedule power-down slot
// - bit 11 disables over-voltage protection
// - bit 10 discharge or float when off
// - bits 6:0 voltage code, 25mV steps
module converter_control_regs
  import conv_regs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic state_machine_reset,
  input wire logic hibernate_reg_bit,
  input wire logic low_power_input_one,
  input wire logic low_power_input_two,
  input wire logic low_power_input_three,
  input wire logic gpio_hibernate_in,
  input wire logic conv2_fault,
  output conv2_ctrl_t conv2_ctrl,
  output conv3_ctrl_t conv3_ctrl,
  output logic irq
);

  typedef struct packed {
    logic [REG_W-1:0] boost_control;
    logic [REG_W-1:0] boost_sequencing;
    logic [REG_W-1:0] third_control;
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] enable;
    logic fault_prev;
    logic sleep_prev;
    logic aw_got;
    logic w_got;
    logic [9:0] waddr;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic irq;
    conv2_ctrl_t c2;
    conv3_ctrl_t c3;
  } state_t;

  state_t s;
  state_t next_s;

  // Byte-lane merge restricted to implemented bits
  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old, input logic [DATA_W-1:0] d,
                                              input logic [3:0] strb, input logic [REG_W-1:0] mask);
    logic [REG_W-1:0] r;
    r = old;
    if (strb[0])
    begin
      r[7:0] = d[7:0];
    end
    if (strb[1])
    begin
      r[15:8] = d[15:8];
    end
    return r & mask;
  endfunction

  function automatic logic mapped(input logic [9:0] idx);
    return idx == IDX_BOOST_CONTROL || idx == IDX_BOOST_SEQUENCING || idx == IDX_THIRD_CONTROL ||
           idx == IDX_IRQ_STATUS || idx == IDX_IRQ_CLEAR || idx == IDX_IRQ_ENABLE;
  endfunction

  logic sleep_src;
  logic sleep_sel;
  logic fault_edge;
  logic [1:0] fault_act;
  logic [9:0] ridx;
  logic [3:0] up_slot;
  logic [3:0] down_slot;
  logic [IRQ_W-1:0] clr;
  logic [IRQ_W-1:0] events;

  always_comb
  begin
    next_s = s;
    clr = '0;
    ridx = s_axi_araddr[ADDR_W-1:2];

    // Write address and data are taken independently, in either order
    if (s_axi_awvalid && s.awready)
    begin
      next_s.aw_got = 1'b1;
      next_s.awready = 1'b0;
      next_s.waddr = s_axi_awaddr[ADDR_W-1:2];
    end
    if (s_axi_wvalid && s.wready)
    begin
      next_s.w_got = 1'b1;
      next_s.wready = 1'b0;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.aw_got && s.w_got)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = mapped(s.waddr) ? RESP_OKAY : RESP_SLVERR;
      case (s.waddr)
        IDX_BOOST_CONTROL:
          next_s.boost_control = merge(s.boost_control, s.wdata, s.wstrb, MASK_BOOST_CONTROL);
        IDX_BOOST_SEQUENCING:
          next_s.boost_sequencing = merge(s.boost_sequencing, s.wdata, s.wstrb, MASK_BOOST_SEQUENCING);
        IDX_THIRD_CONTROL:
          next_s.third_control = merge(s.third_control, s.wdata, s.wstrb, MASK_THIRD_CONTROL);
        IDX_IRQ_CLEAR:
          clr = s.wstrb[0] ? s.wdata[IRQ_W-1:0] : '0;
        IDX_IRQ_ENABLE:
          next_s.enable = s.wstrb[0] ? s.wdata[IRQ_W-1:0] : s.enable;
        default:
          next_s.bresp = next_s.bresp;
      endcase
    end
    if (s.bvalid && s_axi_bready)
    begin
      next_s.bvalid = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end

    if (s_axi_arvalid && s.arready)
    begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
      case (ridx)
        IDX_BOOST_CONTROL: next_s.rdata = {16'h0000, s.boost_control};
        IDX_BOOST_SEQUENCING: next_s.rdata = {16'h0000, s.boost_sequencing};
        IDX_THIRD_CONTROL: next_s.rdata = {16'h0000, s.third_control};
        IDX_IRQ_STATUS: next_s.rdata = {30'h0, s.status};
        IDX_IRQ_ENABLE: next_s.rdata = {30'h0, s.enable};
        default: next_s.rdata = 32'h00000000;
      endcase
    end
    if (s.rvalid && s_axi_rready)
    begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end

    // Power state machine reset restores the fields, over any write in flight
    if (state_machine_reset)
    begin
      next_s.boost_control = RST_BOOST_CONTROL;
      next_s.boost_sequencing = RST_BOOST_SEQUENCING;
      next_s.third_control = {9'h000, RST_THIRD_VOLT};
    end

    case (s.boost_control[C2_SLEEP_SRC_LSB +: 2])
      2'h0: sleep_src = hibernate_reg_bit;
      2'h1: sleep_src = low_power_input_one;
      2'h2: sleep_src = low_power_input_two;
      default: sleep_src = low_power_input_three;
    endcase
    sleep_sel = sleep_src | gpio_hibernate_in;

    // Faults are taken on their rising edge
    fault_edge = conv2_fault & ~s.fault_prev;
    fault_act = s.boost_sequencing[C2_FAULT_ACT_LSB +: 2];
    next_s.fault_prev = conv2_fault;
    next_s.sleep_prev = sleep_sel;

    events = '0;
    events[IRQ_FAULT] = fault_edge;
    events[IRQ_SLEEP] = sleep_sel & ~s.sleep_prev;
    // New events win over a clear in the same cycle
    next_s.status = (s.status & ~clr) | events;
    next_s.irq = |(next_s.status & next_s.enable);

    next_s.c2.switch_mode = s.boost_control[C2_TOPOLOGY_BIT];
    next_s.c2.sleep_selected = sleep_sel;
    next_s.c2.output_disabled = sleep_sel & s.boost_control[C2_SLEEP_RESP_BIT];
    next_s.c2.low_peak_limit = s.boost_control[C2_PEAK_LIMIT_BIT];
    next_s.c2.feedback_source = s.boost_control[C2_FEEDBACK_LSB +: 2];
    if (s.boost_control[C2_FEEDBACK_LSB +: 2] == FB_INTERNAL_DIVIDER)
    begin
      next_s.c2.ramp_range = RAMP_LOWEST;
    end
    else
    begin
      next_s.c2.ramp_range = {s.boost_control[C2_RAMP_HI_BIT], s.boost_control[C2_RAMP_LO_BIT]};
    end
    up_slot = s.boost_sequencing[C2_UP_SLOT_LSB +: 4];
    down_slot = s.boost_sequencing[C2_DOWN_SLOT_LSB +: 4];
    next_s.c2.up_slot = up_slot;
    next_s.c2.up_never = up_slot == SLOT_NEVER;
    next_s.c2.up_on_active = up_slot == SLOT_ALL_ONES;
    next_s.c2.down_slot = down_slot;
    next_s.c2.down_on_off_entry = down_slot == SLOT_NEVER || down_slot == SLOT_ALL_ONES;
    // Reserved action code shuts the system down like code 10
    next_s.c2.shutdown_converter = fault_edge && fault_act == FAULT_CONV_OFF;
    next_s.c2.shutdown_system = fault_edge && fault_act[1];

    next_s.c3.overvolt_protect_en = ~s.third_control[C3_OVP_OFF_BIT];
    next_s.c3.discharge_en = ~s.third_control[C3_FLOAT_BIT];
    // Codes above the top step are held at the maximum output
    if (s.third_control[C3_VOLT_LSB +: 7] > VOLT_CODE_MAX)
    begin
      next_s.c3.voltage_code = VOLT_CODE_MAX;
    end
    else
    begin
      next_s.c3.voltage_code = s.third_control[C3_VOLT_LSB +: 7];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
      s.boost_control <= RST_BOOST_CONTROL;
      s.boost_sequencing <= RST_BOOST_SEQUENCING;
      s.third_control <= {9'h000, RST_THIRD_VOLT};
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.c2.ramp_range <= RAMP_LOWEST;
      s.c2.up_never <= 1'b1;
      s.c2.down_on_off_entry <= 1'b1;
      s.c3.overvolt_protect_en <= 1'b1;
      s.c3.discharge_en <= 1'b1;
      s.c3.voltage_code <= RST_THIRD_VOLT;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign conv2_ctrl = s.c2;
  assign conv3_ctrl = s.c3;
  assign irq = s.irq;

endmodule // converter_control_regs

//--- verif/converter_control_properties.sv
// Port-level timing and field decode properties of the converter control bank
`timescale 1ns/1ns
module converter_control_properties
  import conv_regs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic state_machine_reset,
  input wire logic gpio_hibernate_in,
  input wire conv2_ctrl_t conv2_ctrl,
  input wire conv3_ctrl_t conv3_ctrl
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_smr_held;
    state_machine_reset [*2];
  endsequence
  property p_wr_answer; s_wr_taken |-> ##2 s_axi_bvalid; endproperty
  property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_busy_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_ramp_forced;
    conv2_ctrl.feedback_source == FB_INTERNAL_DIVIDER |-> conv2_ctrl.ramp_range == RAMP_LOWEST;
  endproperty
  property p_volt_max; conv3_ctrl.voltage_code <= VOLT_CODE_MAX; endproperty
  property p_up_codes;
    conv2_ctrl.up_never == (conv2_ctrl.up_slot == SLOT_NEVER)
      && conv2_ctrl.up_on_active == (conv2_ctrl.up_slot == SLOT_ALL_ONES);
  endproperty
  property p_down_codes;
    conv2_ctrl.down_on_off_entry == (conv2_ctrl.down_slot == SLOT_NEVER || conv2_ctrl.down_slot == SLOT_ALL_ONES);
  endproperty
  property p_pulse; conv2_ctrl.shutdown_converter |=> !conv2_ctrl.shutdown_converter; endproperty
  property p_sm_reset;
    s_smr_held |=> conv3_ctrl.overvolt_protect_en && conv3_ctrl.discharge_en
      && conv3_ctrl.voltage_code == RST_THIRD_VOLT;
  endproperty
  property p_gpio_sleep; gpio_hibernate_in [*3] |-> conv2_ctrl.sleep_selected; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response late");
  a_rd_answer: assert property (p_rd_answer) else $error("read response late");
  a_busy_refuse: assert property (p_busy_refuse) else $error("write accepted while busy");
  a_ramp_forced: assert property (p_ramp_forced) else $error("ramp not forced lowest");
  a_volt_max: assert property (p_volt_max) else $error("voltage code above maximum");
  a_up_codes: assert property (p_up_codes) else $error("start slot decode wrong");
  a_down_codes: assert property (p_down_codes) else $error("stop slot decode wrong");
  a_pulse: assert property (p_pulse) else $error("shutdown pulse too long");
  a_sm_reset: assert property (p_sm_reset) else $error("third converter not reset");
  a_gpio_sleep: assert property (p_gpio_sleep) else $error("pin sleep ignored");
endmodule // converter_control_properties
bind converter_control_regs converter_control_properties converter_control_properties_inst (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .state_machine_reset, .gpio_hibernate_in, .conv2_ctrl, .conv3_ctrl);

//--- verif/test_converter_control_regs.sv
// Self-checking bench of the converter control bank
`timescale 1ns/1ns
module test_converter_control_regs
  import conv_regs_pkg::*;
;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic smr, hib_bit, lp1, lp2, lp3, gpio_hib, fault, irq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  conv2_ctrl_t c2;
  conv3_ctrl_t c3;
  int n_mismatch, cmp_count;
  logic [3:0] codes [4] = '{4'h0, 4'h1, 4'he, 4'hf};
  converter_control_regs converter_control_regs_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .state_machine_reset(smr), .hibernate_reg_bit(hib_bit),
    .low_power_input_one(lp1), .low_power_input_two(lp2), .low_power_input_three(lp3),
    .gpio_hibernate_in(gpio_hib), .conv2_fault(fault), .conv2_ctrl(c2), .conv3_ctrl(c3), .irq(irq));
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic finish_test;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [15:0] d, input logic [1:0] er);
    logic aw_open;
    logic w_open;
    logic b_open;
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= {16'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_open = 1'b1;
    w_open = 1'b1;
    b_open = 1'b1;
    // Each channel drops at its own ready; the answer is taken whenever it comes
    while (b_open)
    begin
      @(posedge aclk);
      if (aw_open && awready)
      begin
        awvalid <= 1'b0;
        aw_open = 1'b0;
      end
      if (w_open && wready)
      begin
        wvalid <= 1'b0;
        w_open = 1'b0;
      end
      if (bvalid)
      begin
        bready <= 1'b0;
        b_open = 1'b0;
        cmp("bresp", {30'h0, er}, {30'h0, bresp});
      end
    end
    tick(2);
  endtask
  task automatic rd(input logic [9:0] idx, input logic [15:0] exp, input logic [1:0] er);
    logic ar_open;
    logic r_open;
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar_open = 1'b1;
    r_open = 1'b1;
    while (r_open)
    begin
      @(posedge aclk);
      if (ar_open && arready)
      begin
        arvalid <= 1'b0;
        ar_open = 1'b0;
      end
      if (rvalid)
      begin
        rready <= 1'b0;
        r_open = 1'b0;
        cmp("rdata", {16'h0, exp}, rdata);
        cmp("rresp", {30'h0, er}, {30'h0, rresp});
      end
    end
  endtask
  task automatic t_reset;
    rd(IDX_BOOST_CONTROL, RST_BOOST_CONTROL, RESP_OKAY);
    rd(IDX_BOOST_SEQUENCING, RST_BOOST_SEQUENCING, RESP_OKAY);
    rd(IDX_THIRD_CONTROL, 16'h0000, RESP_OKAY);
    cmp("ovp_en", 1, c3.overvolt_protect_en);
    cmp("discharge", 1, c3.discharge_en);
  endtask
  task automatic t_control;
    wr(IDX_BOOST_CONTROL, 16'hffff, RESP_OKAY);
    cmp("switch", 1, c2.switch_mode);
    cmp("low_peak", 1, c2.low_peak_limit);
    rd(IDX_BOOST_CONTROL, MASK_BOOST_CONTROL, RESP_OKAY);
    wr(IDX_BOOST_CONTROL, 16'h0001, RESP_OKAY);
    cmp("switch", 0, c2.switch_mode);
    cmp("low_peak", 0, c2.low_peak_limit);
    cmp("ramp", 0, c2.ramp_range);
    cmp("fb", 1, c2.feedback_source);
    wr(IDX_BOOST_CONTROL, 16'h0012, RESP_OKAY);
    cmp("ramp", 2, c2.ramp_range);
    cmp("fb", 2, c2.feedback_source);
    wr(IDX_BOOST_CONTROL, 16'h000b, RESP_OKAY);
    cmp("ramp", 3, c2.ramp_range);
  endtask
  task automatic t_third;
    wr(IDX_THIRD_CONTROL, 16'hffff, RESP_OKAY);
    cmp("ovp_en", 0, c3.overvolt_protect_en);
    cmp("discharge", 0, c3.discharge_en);
    cmp("vcode", VOLT_CODE_MAX, c3.voltage_code);
    rd(IDX_THIRD_CONTROL, MASK_THIRD_CONTROL, RESP_OKAY);
    wr(IDX_THIRD_CONTROL, 16'h0021, RESP_OKAY);
    cmp("vcode", 7'h21, c3.voltage_code);
  endtask
  task automatic t_seq;
    foreach (codes[i])
    begin
      wr(IDX_BOOST_SEQUENCING, {2'h0, codes[i], codes[i], 6'h0}, RESP_OKAY);
      cmp("up_slot", codes[i], c2.up_slot);
      cmp("up_never", codes[i] == 4'h0, c2.up_never);
      cmp("up_active", codes[i] == 4'hf, c2.up_on_active);
      cmp("down_slot", codes[i], c2.down_slot);
      cmp("down_off", codes[i] == 4'h0 || codes[i] == 4'hf, c2.down_on_off_entry);
    end
  endtask
  task automatic t_fault;
    for (int act = 0; act < 5; act++)
    begin
      // Last pass runs with the interrupt masked
      wr(IDX_IRQ_ENABLE, {15'h0, act < 4}, RESP_OKAY);
      wr(IDX_BOOST_SEQUENCING, {act[1:0], 14'h0}, RESP_OKAY);
      @(posedge aclk);
      fault <= 1'b1;
      tick(1);
      cmp("sd_conv", act == 1, c2.shutdown_converter);
      cmp("sd_sys", act == 2 || act == 3, c2.shutdown_system);
      tick(1);
      cmp("irq", act < 4, irq);
      rd(IDX_IRQ_STATUS, 16'h0001, RESP_OKAY);
      fault <= 1'b0;
      wr(IDX_IRQ_CLEAR, 16'h0001, RESP_OKAY);
      cmp("irq", 0, irq);
    end
  endtask
  task automatic t_sleep;
    for (int src = 0; src < 4; src++)
    begin
      wr(IDX_BOOST_CONTROL, {4'h1, 2'h0, src[1:0], 8'h0}, RESP_OKAY);
      @(posedge aclk);
      {lp3, lp2, lp1, hib_bit} <= 4'h1 << src;
      tick(3);
      cmp("sleep", 1, c2.sleep_selected);
      cmp("out_off", 1, c2.output_disabled);
      @(posedge aclk);
      {lp3, lp2, lp1, hib_bit} <= ~(4'h1 << src);
      tick(3);
      cmp("sleep", 0, c2.sleep_selected);
      @(posedge aclk);
      gpio_hib <= 1'b1;
      tick(4);
      cmp("sleep", 1, c2.sleep_selected);
      @(posedge aclk);
      gpio_hib <= 1'b0;
    end
    wr(IDX_BOOST_CONTROL, 16'h0000, RESP_OKAY);
    @(posedge aclk);
    hib_bit <= 1'b1;
    tick(3);
    cmp("out_off", 0, c2.output_disabled);
  endtask
  task automatic t_misc;
    wr(IDX_THIRD_CONTROL, 16'h0c33, RESP_OKAY);
    @(posedge aclk);
    smr <= 1'b1;
    tick(3);
    cmp("ovp_en", 1, c3.overvolt_protect_en);
    cmp("vcode", RST_THIRD_VOLT, c3.voltage_code);
    rd(IDX_THIRD_CONTROL, 16'h0000, RESP_OKAY);
    smr <= 1'b0;
    rd(10'h000, 16'h0000, RESP_SLVERR);
    wr(10'h001, 16'hffff, RESP_SLVERR);
  endtask
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, smr, hib_bit, lp1, lp2, lp3, gpio_hib, fault} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    tick(1);
    t_reset;
    t_control;
    t_third;
    t_seq;
    t_fault;
    t_sleep;
    t_misc;
    finish_test;
  end
  initial
  begin
    // Whole run needs a few hundred cycles
    #100000;
    n_mismatch++;
    finish_test;
  end
endmodule // test_converter_control_regs
